/* pkg/ldsc_pkg.sv */
// Package of constants for the loop converter serial control block
package ldsc_pkg;
  localparam int          FRAME_BITS    = 24;
  localparam int          SYS_CLK_HZ    = 25000000;
  localparam int          WD_MS_0       = 50;
  localparam int          WD_MS_1       = 100;
  localparam int          WD_MS_2       = 500;
  localparam int          WD_MS_3       = 1000;
  localparam int          WD_MS_4       = 2000;
  localparam int          WD_MS_5       = 3000;
  localparam int          WD_MS_6       = 4000;
  localparam int          WD_MS_7       = 5000;
  localparam int          CYC_PER_MS    = SYS_CLK_HZ / 1000;
  localparam logic [15:0] OUT_RST       = 16'h0000;
  localparam logic [15:0] ALARM_UP_CODE = 16'hFFFF;
  localparam logic [15:0] ALARM_DN_CODE = 16'h0000;
  localparam int          ST_WDOG       = 0;
  localparam int          ST_PEC        = 1;
  localparam int          ST_RANGE      = 2;
  localparam int          ST_VLOOP      = 3;
  localparam int          ST_TEMP       = 4;
  localparam int          ST_BITS       = 5;
  localparam logic [4:0]  ST_RST        = 5'h00;
  localparam logic [4:0]  MASK_RST      = 5'h1F;
  localparam logic [7:0]  REG_STATUS    = 8'h00;
  localparam logic [7:0]  REG_MASK      = 8'h04;
  localparam logic [7:0]  REG_CONFIG    = 8'h08;
  localparam logic [7:0]  REG_INPUT     = 8'h0C;
  localparam logic [7:0]  REG_OUTPUT    = 8'h10;
  localparam logic [7:0]  REG_PINS      = 8'h14;
  localparam int          CFG_WD_EN     = 3;
  localparam logic [3:0]  CFG_RST       = 4'h0;
  localparam logic [3:0]  PIN_IDLE      = 4'hA;
endpackage

/* core/ldsc_core.sv */
// Serial control logic of the loop converter: shift port, registers, faults
//Contract
// - Read-back bit driven on rising serial clock, stable at next falling edge.
// - While frame select low, shift serial_in on every falling serial clock edge.
// - Frame select low frames transfer; its rising edge latches the shift register.
// - Load pin held low: output register updates on frame select rising edge.
// - Load pin high during write: input only, output waits for load falling edge.
// - Alert output high on watchdog, check code, range, loop voltage, temperature faults.
// - Alarm direction pin high selects upscale alarm, low selects downscale.
// - Resistor select high uses internal resistor, low the external one.
// - Two span select pins together choose the loop current span.
// - Serial out released to high impedance once frame select returns high.
// - Three-bit setting picks watchdog timeout from 50 ms to 5000 ms.
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module ldsc_core #(
  parameter int FRAME_BITS = ldsc_pkg::FRAME_BITS,
  parameter int CYC_PER_MS = ldsc_pkg::CYC_PER_MS
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_clk_en,
  input  wire logic        i_serial_clock_in,
  input  wire logic        i_frame_select_n,
  input  wire logic        i_serial_in,
  input  wire logic        i_load_output_n,
  input  wire logic        i_alarm_dir_select,
  input  wire logic        i_resistor_select,
  input  wire logic        i_span_select0,
  input  wire logic        i_span_select1,
  input  wire logic        i_timeout_sel_bit0,
  input  wire logic        i_timeout_sel_bit1,
  input  wire logic        i_timeout_sel_bit2,
  input  wire logic        i_range_fault,
  input  wire logic        i_vloop_fault,
  input  wire logic        i_temp_fault,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  output logic             o_serial_out,
  output logic             o_serial_out_oe,
  output logic             o_error_alert_out,
  output logic             o_irq,
  output logic      [15:0] o_output_code,
  output logic             o_alarm_up,
  output logic             o_int_resistor,
  output logic      [1:0]  o_span
);
  // Parameter limits the logic can serve
  if (FRAME_BITS < 17 || FRAME_BITS > 32) begin : g_frame_bits_check
    $error("FRAME_BITS out of range");
  end
  if (CYC_PER_MS < 1 || CYC_PER_MS > 131072) begin : g_cyc_per_ms_check
    $error("CYC_PER_MS out of range");
  end

  typedef enum logic [1:0] {LDSC_IDLE, LDSC_SHIFT, LDSC_DONE} ldsc_state_t;

  // Two-flop synchronisers for the pin inputs, then one history stage
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [3:0] hist_reg;
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      sync1_reg <= ldsc_pkg::PIN_IDLE;
      sync2_reg <= ldsc_pkg::PIN_IDLE;
      hist_reg  <= ldsc_pkg::PIN_IDLE;
    end else if (i_clk_en) begin
      sync1_reg <= {i_load_output_n, i_serial_in, i_frame_select_n, i_serial_clock_in};
      sync2_reg <= sync1_reg;
      hist_reg  <= sync2_reg;
    end
  end

  logic sclk_s;
  logic fs_s;
  logic sdi_s;
  logic ld_s;
  logic sclk_rise;
  logic sclk_fall;
  logic fs_rise;
  logic fs_fall;
  logic ld_fall;
  assign sclk_s    = sync2_reg[0];
  assign fs_s      = sync2_reg[1];
  assign sdi_s     = sync2_reg[2];
  assign ld_s      = sync2_reg[3];
  assign sclk_rise = sclk_s && !hist_reg[0];
  assign sclk_fall = !sclk_s && hist_reg[0];
  assign fs_rise   = fs_s && !hist_reg[1];
  assign fs_fall   = !fs_s && hist_reg[1];
  assign ld_fall   = !ld_s && hist_reg[3];

  // Strap pins pass two flip-flops before capture
  logic [6:0] strap_s1_reg;
  logic [6:0] strap_s2_reg;
  always_ff @(posedge i_sys_clk) begin
    if (i_clk_en) begin
      strap_s1_reg <= {i_alarm_dir_select, i_resistor_select, i_span_select1, i_span_select0,
                       i_timeout_sel_bit0, i_timeout_sel_bit1, i_timeout_sel_bit2};
      strap_s2_reg <= strap_s1_reg;
    end
  end

  // Static pins caught once after reset release
  logic       strap_done_reg;
  logic [1:0] strap_wait_reg;
  logic       alarm_up_reg;
  logic       int_res_reg;
  logic [1:0] span_reg;
  logic [2:0] wd_sel_reg;
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      strap_done_reg <= 1'b0;
      strap_wait_reg <= 2'h0;
      alarm_up_reg   <= 1'b0;
      int_res_reg    <= 1'b0;
      span_reg       <= 2'h0;
      wd_sel_reg     <= 3'h0;
    end else if (i_clk_en && !strap_done_reg) begin
      if (strap_wait_reg != 2'h2) begin
        strap_wait_reg <= strap_wait_reg + 2'h1;
      end else begin
        strap_done_reg <= 1'b1;
        alarm_up_reg   <= strap_s2_reg[6];
        int_res_reg    <= strap_s2_reg[5];
        span_reg       <= strap_s2_reg[4:3];
        wd_sel_reg     <= strap_s2_reg[2:0];
      end
    end
  end

  // Serial frame engine
  ldsc_state_t                  state_reg;
  logic        [FRAME_BITS-1:0] shift_reg;
  logic        [FRAME_BITS-1:0] tx_reg;
  logic        [5:0]            cnt_reg;
  logic                         frame_ok;
  assign frame_ok = (cnt_reg == 6'(FRAME_BITS));
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      state_reg <= LDSC_IDLE;
      shift_reg <= '0;
      cnt_reg   <= 6'h00;
    end else if (i_clk_en) begin
      case (state_reg)
        LDSC_IDLE: begin
          if (fs_fall) begin
            state_reg <= LDSC_SHIFT;
            cnt_reg   <= 6'h00;
          end
        end
        LDSC_SHIFT: begin
          if (fs_rise) begin
            state_reg <= LDSC_DONE;
          end else if (sclk_fall && !fs_s) begin
            shift_reg <= {shift_reg[FRAME_BITS-2:0], sdi_s};
            if (cnt_reg != 6'h3F) begin
              cnt_reg <= cnt_reg + 6'h01;
            end
          end
        end
        LDSC_DONE: begin
          state_reg <= LDSC_IDLE;
        end
        default:   state_reg <= LDSC_IDLE;
      endcase
    end
  end

  // Check code: low byte is XOR of the upper bytes
  function automatic logic [7:0] ldsc_crc(input logic [FRAME_BITS-1:0] f);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 8; i + 7 < FRAME_BITS; i += 8) begin
      c = c ^ f[i +: 8];
    end
    return c;
  endfunction

  logic pec_err;
  logic wr_ok;
  assign pec_err = (state_reg == LDSC_DONE) && frame_ok && (ldsc_crc(shift_reg) != shift_reg[7:0]);
  assign wr_ok   = (state_reg == LDSC_DONE) && frame_ok && !pec_err;

  // Input and output registers
  logic [15:0] input_reg;
  logic [15:0] output_reg;
  logic        pending_reg;
  logic        alarm_act;
  logic [ldsc_pkg::ST_BITS-1:0] status_reg;
  assign alarm_act = status_reg[ldsc_pkg::ST_WDOG] || status_reg[ldsc_pkg::ST_PEC];
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      input_reg   <= ldsc_pkg::OUT_RST;
      output_reg  <= ldsc_pkg::OUT_RST;
      pending_reg <= 1'b0;
    end else if (i_clk_en) begin
      if (wr_ok) begin
        input_reg <= shift_reg[FRAME_BITS-1 -: 16];
        if (!ld_s) begin
          output_reg  <= shift_reg[FRAME_BITS-1 -: 16];
          pending_reg <= 1'b0;
        end else begin
          pending_reg <= 1'b1;
        end
      end else if (i_wr && i_addr == ldsc_pkg::REG_INPUT) begin
        input_reg   <= i_wdata[15:0];
        pending_reg <= 1'b1;
      end else if (ld_fall && pending_reg) begin
        output_reg  <= input_reg;
        pending_reg <= 1'b0;
      end
    end
  end

  // Read-back word: status in the upper bits, loaded at frame start
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      tx_reg <= '0;
    end else if (i_clk_en) begin
      if (state_reg == LDSC_IDLE && fs_fall) begin
        tx_reg <= {{(FRAME_BITS-ldsc_pkg::ST_BITS){1'b0}}, status_reg} << (FRAME_BITS - 8);
      end else if (state_reg == LDSC_SHIFT && sclk_rise && !fs_s) begin
        tx_reg <= {tx_reg[FRAME_BITS-2:0], 1'b0};
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_serial_out    <= 1'b0;
      o_serial_out_oe <= 1'b0;
    end else if (i_clk_en) begin
      o_serial_out_oe <= !fs_s;
      if (!fs_s && sclk_rise) begin
        o_serial_out <= tx_reg[FRAME_BITS-1];
      end
    end
  end

  // Watchdog on serial activity
  function automatic logic [12:0] ldsc_wd_ms(input logic [2:0] s);
    case (s)
      3'h0:    return 13'(ldsc_pkg::WD_MS_0);
      3'h1:    return 13'(ldsc_pkg::WD_MS_1);
      3'h2:    return 13'(ldsc_pkg::WD_MS_2);
      3'h3:    return 13'(ldsc_pkg::WD_MS_3);
      3'h4:    return 13'(ldsc_pkg::WD_MS_4);
      3'h5:    return 13'(ldsc_pkg::WD_MS_5);
      3'h6:    return 13'(ldsc_pkg::WD_MS_6);
      default: return 13'(ldsc_pkg::WD_MS_7);
    endcase
  endfunction

  logic [3:0]  cfg_reg;
  logic [16:0] pre_reg;
  logic [12:0] ms_reg;
  logic        wd_evt;
  logic        tick;
  assign tick   = (pre_reg == 17'(CYC_PER_MS - 1));
  assign wd_evt = cfg_reg[ldsc_pkg::CFG_WD_EN] && tick && (ms_reg + 13'h0001 >= ldsc_wd_ms(wd_sel_reg));
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      pre_reg <= 17'h00000;
      ms_reg  <= 13'h0000;
    end else if (i_clk_en) begin
      if (wr_ok || !cfg_reg[ldsc_pkg::CFG_WD_EN]) begin
        pre_reg <= 17'h00000;
        ms_reg  <= 13'h0000;
      end else if (tick) begin
        pre_reg <= 17'h00000;
        ms_reg  <= wd_evt ? 13'h0000 : ms_reg + 13'h0001;
      end else begin
        pre_reg <= pre_reg + 17'h00001;
      end
    end
  end

  // Sticky fault status, mask and config registers
  logic [ldsc_pkg::ST_BITS-1:0] mask_reg;
  logic [ldsc_pkg::ST_BITS-1:0] evt;
  logic [ldsc_pkg::ST_BITS-1:0] st_clr;
  assign evt = {i_temp_fault, i_vloop_fault, i_range_fault, pec_err, wd_evt};
  assign st_clr = (i_wr && i_addr == ldsc_pkg::REG_STATUS) ? i_wdata[ldsc_pkg::ST_BITS-1:0] : '0;
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      status_reg <= ldsc_pkg::ST_RST;
      mask_reg   <= ldsc_pkg::MASK_RST;
      cfg_reg    <= ldsc_pkg::CFG_RST;
    end else if (i_clk_en) begin
      status_reg <= (status_reg & ~st_clr) | evt;
      if (i_wr && i_addr == ldsc_pkg::REG_MASK) begin
        mask_reg <= i_wdata[ldsc_pkg::ST_BITS-1:0];
      end
      if (i_wr && i_addr == ldsc_pkg::REG_CONFIG) begin
        cfg_reg <= i_wdata[3:0];
      end
    end
  end

  // Register read port and registered outputs
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_rdata           <= 32'h00000000;
      o_error_alert_out <= 1'b0;
      o_irq             <= 1'b0;
      o_output_code     <= ldsc_pkg::OUT_RST;
      o_alarm_up        <= 1'b0;
      o_int_resistor    <= 1'b0;
      o_span            <= 2'h0;
    end else if (i_clk_en) begin
      o_error_alert_out <= |status_reg;
      o_irq             <= |(status_reg & mask_reg);
      o_alarm_up        <= alarm_up_reg;
      o_int_resistor    <= int_res_reg;
      o_span            <= span_reg;
      if (alarm_act) begin
        o_output_code <= alarm_up_reg ? ldsc_pkg::ALARM_UP_CODE : ldsc_pkg::ALARM_DN_CODE;
      end else begin
        o_output_code <= output_reg;
      end
      o_rdata <= 32'h00000000;
      if (i_rd) begin
        case (i_addr)
          ldsc_pkg::REG_STATUS: o_rdata <= 32'(status_reg);
          ldsc_pkg::REG_MASK:   o_rdata <= 32'(mask_reg);
          ldsc_pkg::REG_CONFIG: o_rdata <= 32'(cfg_reg);
          ldsc_pkg::REG_INPUT:  o_rdata <= {15'h0000, pending_reg, input_reg};
          ldsc_pkg::REG_OUTPUT: o_rdata <= 32'(output_reg);
          ldsc_pkg::REG_PINS:   o_rdata <= 32'({wd_sel_reg, span_reg, int_res_reg, alarm_up_reg});
          default:              o_rdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // ldsc_core

/* tb/ldsc_properties.sv */
// Checker of the serial port and fault output behaviour
`timescale 1ns/1ps
module ldsc_properties (
  input wire logic       i_sys_clk,
  input wire logic       i_rst_n,
  input wire logic       i_serial_clock_in,
  input wire logic       i_frame_select_n,
  input wire logic       i_range_fault,
  input wire logic       i_vloop_fault,
  input wire logic       i_temp_fault,
  input wire logic       i_wr,
  input wire logic       o_serial_out,
  input wire logic       o_serial_out_oe,
  input wire logic       o_error_alert_out,
  input wire logic       o_irq,
  input wire logic       o_alarm_up,
  input wire logic       o_int_resistor,
  input wire logic [1:0] o_span
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);
  sequence s_frame_open;
    $fell(i_frame_select_n);
  endsequence
  sequence s_frame_close;
    $rose(i_frame_select_n);
  endsequence
  a_oe_in_frame: assert property (s_frame_open |-> ##[1:6] o_serial_out_oe)
    else $error("serial out not driven inside frame");
  a_oe_released: assert property (s_frame_close |-> ##[1:6] !o_serial_out_oe)
    else $error("serial out not released after frame");
  a_bit_settled: assert property (o_serial_out_oe && $fell(i_serial_clock_in)
    |-> ##3 $stable(o_serial_out) [*3])
    else $error("read-back bit moved while serial clock low");
  a_range_alert: assert property (i_range_fault |-> ##[1:3] o_error_alert_out)
    else $error("alert missing after range fault");
  a_other_alert: assert property (i_vloop_fault || i_temp_fault
    |-> ##[1:3] o_error_alert_out)
    else $error("alert missing after loop voltage or temperature fault");
  a_irq_alert: assert property (o_irq |-> o_error_alert_out)
    else $error("interrupt without alert");
  a_alert_sticky: assert property (o_error_alert_out && !i_wr && !$past(i_wr)
    |=> o_error_alert_out)
    else $error("alert dropped without a clear");
  a_straps_hold: assert property ($past(i_rst_n, 5) && $past(i_rst_n, 4) && $past(i_rst_n, 3)
    && $past(i_rst_n, 2) && $past(i_rst_n)
    |-> $stable(o_span) && $stable(o_alarm_up) && $stable(o_int_resistor))
    else $error("strap outputs changed during operation");
endmodule // ldsc_properties
bind ldsc_core ldsc_properties u_ldsc_properties (.i_sys_clk, .i_rst_n, .i_serial_clock_in,
  .i_frame_select_n, .i_range_fault, .i_vloop_fault, .i_temp_fault, .i_wr, .o_serial_out,
  .o_serial_out_oe, .o_error_alert_out, .o_irq, .o_alarm_up, .o_int_resistor, .o_span);

/* tb/ldsc_host_model.sv */
// Host model of the four-wire serial port: drives clock, select and data in, samples serial out
`timescale 1ns/1ps
module ldsc_host_model (
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_sdi,
  input  wire logic i_sdo,
  input  wire logic i_sdo_oe
);
  localparam time HALF = 160ns;
  logic last;
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_sdi  = 1'b0;
    last   = 1'b0;
  end
  task automatic frame(input logic [23:0] w, input int n, output logic [23:0] rb);
    rb = 24'h000000;
    o_cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      #HALF o_sclk = 1'b1;
      o_sdi = w[23 - i];
      #HALF o_sclk = 1'b0;
      last = i_sdo_oe ? i_sdo : ~last;
      rb[23 - i] = last;
    end
    #HALF o_cs_n = 1'b1;
    o_sdi = ~o_sdi;
    #HALF;
  endtask
endmodule // ldsc_host_model

/* tb/loop_dac_serial_control_tb.sv */
// Self-checking bench of the loop converter serial control block
`timescale 1ns/1ps
module loop_dac_serial_control_tb;
  localparam int CPM = 10;
  logic        clk, rst_n, ld_n, wr, rd, f_rng, f_vl, f_tp;
  logic [6:0]  st;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [15:0] d, d2, acode;
  logic [23:0] rb;
  wire         sclk, cs_n, sdi, serial_out, sdo_oe, alert, irq, alarm_up, int_res;
  wire  [1:0]  span;
  wire  [15:0] code;
  wire  [31:0] rdata;
  integer      seed, miscompares, total_checks;
  int          ms [8] = '{ldsc_pkg::WD_MS_0, ldsc_pkg::WD_MS_1, ldsc_pkg::WD_MS_2,
    ldsc_pkg::WD_MS_3, ldsc_pkg::WD_MS_4, ldsc_pkg::WD_MS_5, ldsc_pkg::WD_MS_6,
    ldsc_pkg::WD_MS_7};
  ldsc_host_model u_ldsc_host_model (.o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi),
    .i_sdo(serial_out), .i_sdo_oe(sdo_oe));
  ldsc_core #(.CYC_PER_MS(CPM)) u_ldsc_core (.i_sys_clk(clk), .i_rst_n(rst_n),
    .i_clk_en(1'b1), .i_serial_clock_in(sclk), .i_frame_select_n(cs_n), .i_serial_in(sdi),
    .i_load_output_n(ld_n), .i_alarm_dir_select(st[6]), .i_resistor_select(st[5]),
    .i_span_select0(st[4]), .i_span_select1(st[3]), .i_timeout_sel_bit0(st[2]),
    .i_timeout_sel_bit1(st[1]), .i_timeout_sel_bit2(st[0]), .i_range_fault(f_rng),
    .i_vloop_fault(f_vl), .i_temp_fault(f_tp), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .o_serial_out(serial_out), .o_serial_out_oe(sdo_oe),
    .o_error_alert_out(alert), .o_irq(irq), .o_output_code(code), .o_alarm_up(alarm_up),
    .o_int_resistor(int_res), .o_span(span));
  always #20 clk = ~clk;
  task automatic end_of_test();
    if (miscompares == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [23:0] mk_frame(input logic [15:0] v, input logic [7:0] bad);
    return {v, v[15:8] ^ v[7:0] ^ bad};
  endfunction
  function automatic logic [31:0] pins_word(input logic [6:0] s);
    return {25'h0000000, s[2:0], s[3], s[4], s[5], s[6]};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("rdata", rdata, e);
  endtask
  task automatic send(input logic [15:0] v, input logic [7:0] bad, input int n);
    tick(1);
    u_ldsc_host_model.frame(mk_frame(v, bad), n, rb);
    tick(8);
  endtask
  initial begin
    #(40 * 70000);
    miscompares++;
    end_of_test();
  end
  initial begin
    seed = 48;
    miscompares = 0;
    total_checks = 0;
    {clk, rst_n, ld_n, wr, rd, f_rng, f_vl, f_tp} = 8'h00;
    addr = 8'h00;
    wdata = 32'h00000000;
    st = 7'($random(seed));
    acode = st[6] ? ldsc_pkg::ALARM_UP_CODE : ldsc_pkg::ALARM_DN_CODE;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    tick(6);
    chk("alarm_up", alarm_up, st[6]);
    chk("int_res", int_res, st[5]);
    chk("span", span, {st[3], st[4]});
    rreg(ldsc_pkg::REG_PINS, pins_word(st));
    rreg(ldsc_pkg::REG_STATUS, 32'(ldsc_pkg::ST_RST));
    rreg(ldsc_pkg::REG_MASK, 32'(ldsc_pkg::MASK_RST));
    rreg(ldsc_pkg::REG_CONFIG, 32'(ldsc_pkg::CFG_RST));
    rreg(ldsc_pkg::REG_OUTPUT, 32'(ldsc_pkg::OUT_RST));
    rreg(8'hFC, 32'h00000000);
    d = 16'($random(seed));
    send(d, 8'h00, 24);
    chk("output", code, d);
    rreg(ldsc_pkg::REG_INPUT, {16'h0000, d});
    @(posedge clk);
    ld_n <= 1'b1;
    d2 = 16'($random(seed));
    send(d2, 8'h00, 24);
    chk("output", code, d);
    rreg(ldsc_pkg::REG_INPUT, {15'h0000, 1'b1, d2});
    @(posedge clk);
    ld_n <= 1'b0;
    tick(8);
    chk("output", code, d2);
    send(16'($random(seed)), 8'h00, 23);
    rreg(ldsc_pkg::REG_INPUT, {16'h0000, d2});
    send(16'($random(seed)), 8'h01, 24);
    rreg(ldsc_pkg::REG_STATUS, 32'(1 << ldsc_pkg::ST_PEC));
    chk("alarm", code, acode);
    wreg(ldsc_pkg::REG_MASK, 32'h00000000);
    tick(3);
    chk("irq", irq, 1'b0);
    wreg(ldsc_pkg::REG_MASK, 32'(ldsc_pkg::MASK_RST));
    tick(3);
    chk("irq", irq, 1'b1);
    wreg(ldsc_pkg::REG_STATUS, 32'(1 << ldsc_pkg::ST_PEC));
    tick(3);
    chk("irq", irq, 1'b0);
    d = 16'($random(seed));
    @(posedge clk);
    ld_n <= 1'b1;
    wreg(ldsc_pkg::REG_INPUT, 32'(d));
    rreg(ldsc_pkg::REG_INPUT, {15'h0000, 1'b1, d});
    @(posedge clk);
    ld_n <= 1'b0;
    tick(8);
    chk("output", code, d);
    rreg(ldsc_pkg::REG_OUTPUT, 32'(d));
    for (int b = ldsc_pkg::ST_RANGE; b <= ldsc_pkg::ST_TEMP; b++) begin
      @(posedge clk);
      {f_tp, f_vl, f_rng} <= 3'(1 << (b - 2));
      @(posedge clk);
      {f_tp, f_vl, f_rng} <= 3'h0;
      d = 16'($random(seed));
      send(d, 8'h00, 24);
      chk("readback", rb, 24'(1 << (b + 16)));
      chk("output", code, d);
      wreg(ldsc_pkg::REG_STATUS, 32'(1 << b));
      tick(3);
      chk("alert", alert, 1'b0);
    end
    wreg(ldsc_pkg::REG_CONFIG, 32'(1 << ldsc_pkg::CFG_WD_EN));
    tick(ms[{st[2], st[1], st[0]}] * CPM + 40);
    rreg(ldsc_pkg::REG_STATUS, 32'(1 << ldsc_pkg::ST_WDOG));
    chk("alert", alert, 1'b1);
    chk("alarm", code, acode);
    chk("span", span, {st[3], st[4]});
    end_of_test();
  end
endmodule // loop_dac_serial_control_tb
